// ---- hdl/tsrs_top.sv ----
// Purpose: choose torque reference, torque-mode speed limit and internal set speed
// Assumes: analog speed reference arrives as signed mV from same-clock converter logic
// Notes:   control mode and limit source take effect on i_restart only; torque source, presets and cap act at once
`timescale 1ns/1ps
`default_nettype none
module tsrs_top #(
  parameter tsrs_pkg::tsrs_val_t MOTOR_MAX_RPM = 16'sh0bb8,  // 3000
  parameter int                  RATED_RPM     = 3000
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  input  wire logic                i_restart,
  input  wire logic [3:0]          i_control_mode_sel,
  input  wire logic                i_speed_limit_source_sel,
  input  wire logic                i_torque_source_sel,
  input  wire logic [7:0]          i_input_alloc_a,
  input  wire logic [7:0]          i_input_alloc_b,
  input  wire logic                i_prm_we,
  input  wire tsrs_pkg::tsrs_idx_t i_prm_addr,
  input  wire tsrs_pkg::tsrs_val_t i_prm_wdata,
  input  wire logic [7:0]          i_gp_pins,
  input  wire logic                i_direction_sel_in,
  input  wire logic                i_speed_sel_in_a,
  input  wire logic                i_speed_sel_in_b,
  input  wire tsrs_pkg::tsrs_val_t i_analog_speed_mv,
  output var  tsrs_pkg::tsrs_val_t o_speed_limit,
  output var  tsrs_pkg::tsrs_val_t o_torque_ref,
  output var  logic                o_torque_internal,
  output var  tsrs_pkg::tsrs_val_t o_speed_ref,
  output var  logic                o_speed_zero,
  output var  logic                o_prm_reject
);
  import tsrs_pkg::*;

  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  tsrs_mode_e        mode_q;
  logic              lim_src_q;
  tsrs_val_t         cap_q;
  tsrs_val_t         gain_q;
  logic [2:0]        spd_code_q;
  logic              mem_we;
  logic              wr_ok;
  logic              tsel0, tsel1, lsel0, lsel1;
  logic [2:0]        spd_code;
  tsrs_idx_t         trq_addr;
  tsrs_idx_t         spd_addr;
  tsrs_val_t         trq_rd;
  tsrs_val_t         spd_rd;
  tsrs_val_t         cap_eff;
  tsrs_val_t         analog_rpm;
  tsrs_val_t         limit_d;

  // analog magnitude to rpm: gain x 0.1 V means rated speed
  function automatic tsrs_val_t scale_analog(input tsrs_val_t mv, input tsrs_val_t gain);
    int mag;
    int rpm;
    mag = (mv < 0) ? -int'(mv) : int'(mv);  // int math, so the most negative code cannot wrap
    rpm = (mag * RATED_RPM) / (int'(gain) * GAIN_LSB_MV);
    scale_analog = (rpm > int'(SPD_MAX)) ? SPD_MAX : tsrs_val_t'(rpm);
  endfunction

  // pick one synchronised general pin by a 3-bit allocation field
  function automatic logic pick_pin(input logic [SYNC_W-1:0] s, input logic [PIN_IDX_W-1:0] idx);
    pick_pin = s[idx];
  endfunction

  // pins are asynchronous; nothing reads sync1_q but sync2_q
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_direction_sel_in, i_speed_sel_in_a, i_speed_sel_in_b, i_gp_pins};
      sync2_q <= sync1_q;
    end
  end

  // select routing through the two allocation words
  always_comb begin
    tsel0    = pick_pin(sync2_q, i_input_alloc_a[ALLOC_SEL0_LSB +: PIN_IDX_W]);
    tsel1    = pick_pin(sync2_q, i_input_alloc_a[ALLOC_SEL1_LSB +: PIN_IDX_W]);
    lsel0    = pick_pin(sync2_q, i_input_alloc_b[ALLOC_SEL0_LSB +: PIN_IDX_W]);
    lsel1    = pick_pin(sync2_q, i_input_alloc_b[ALLOC_SEL1_LSB +: PIN_IDX_W]);
    spd_code = sync2_q[SYNC_W-1 -: 3];  // direction, select a, select b
    trq_addr = PRM_TRQ1 + tsrs_idx_t'({tsel1, tsel0});
    if (mode_q == TSRS_INT_SPEED) begin
      spd_addr = PRM_SPD1 + tsrs_idx_t'(spd_code) - 4'h1;
    end else begin
      spd_addr = PRM_SPD1 + tsrs_idx_t'({lsel1, lsel0});
    end
  end

  // mode fields only move on restart, so a live edit cannot jolt the loop
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_q    <= TSRS_IDLE;
      lim_src_q <= 1'b0;
    end else if (i_restart) begin
      lim_src_q <= i_speed_limit_source_sel;
      if (i_control_mode_sel == CM_TORQUE) begin
        mode_q <= TSRS_TORQUE;
      end else if (i_control_mode_sel == CM_INT_SPEED) begin
        mode_q <= TSRS_INT_SPEED;
      end else begin
        mode_q <= TSRS_IDLE;
      end
    end
  end

  // write range check; an out-of-range write is dropped and flagged
  always_comb begin
    if (i_prm_addr < PRM_SPD1) begin
      wr_ok = in_range(i_prm_wdata, TRQ_MIN, TRQ_MAX);
    end else if (i_prm_addr <= PRM_SPD7) begin
      wr_ok = in_range(i_prm_wdata, SPD_MIN, SPD_MAX);
    end else if (i_prm_addr == PRM_CAP) begin
      wr_ok = in_range(i_prm_wdata, CAP_MIN, CAP_MAX);
    end else if (i_prm_addr == PRM_GAIN) begin
      wr_ok = in_range(i_prm_wdata, GAIN_MIN, GAIN_MAX);
    end else begin
      wr_ok = 1'b0;
    end
    mem_we = i_prm_we && wr_ok && (i_prm_addr <= PRM_SPD7);
  end

  // cap and gain live here, beside the limit arithmetic
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cap_q        <= CAP_DEF;
      gain_q       <= GAIN_DEF;
      o_prm_reject <= 1'b0;
    end else begin
      o_prm_reject <= i_prm_we && !wr_ok;
      if (i_prm_we && wr_ok && (i_prm_addr == PRM_CAP)) begin
        cap_q <= i_prm_wdata;
      end
      if (i_prm_we && wr_ok && (i_prm_addr == PRM_GAIN)) begin
        gain_q <= i_prm_wdata;
      end
    end
  end

  tsrs_prm_mem u_mem (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_we      (mem_we),
    .i_waddr   (i_prm_addr),
    .i_wdata   (i_prm_wdata),
    .i_raddr_a (trq_addr),
    .i_raddr_b (spd_addr),
    .o_rdata_a (trq_rd),
    .o_rdata_b (spd_rd)
  );

  // limit arithmetic; cap above motor maximum falls back to the maximum
  always_comb begin
    cap_eff    = smin(cap_q, MOTOR_MAX_RPM);
    analog_rpm = scale_analog(i_analog_speed_mv, gain_q);
    if (i_torque_source_sel == TS_INTERNAL) begin
      limit_d = smin(sabs(spd_rd), MOTOR_MAX_RPM);
    end else if (lim_src_q == LS_EXTERNAL) begin
      limit_d = smin(analog_rpm, cap_eff);
    end else begin
      limit_d = cap_eff;
    end
  end

  // code is held one edge so it lines up with the registered preset read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      spd_code_q <= '0;
    end else begin
      spd_code_q <= spd_code;
    end
  end

  // output registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_speed_limit     <= CAP_DEF;
      o_torque_ref      <= TRQ_DEF;
      o_torque_internal <= 1'b0;
      o_speed_ref       <= TRQ_DEF;
      o_speed_zero      <= 1'b1;
    end else begin
      o_speed_limit     <= limit_d;
      o_torque_internal <= (mode_q == TSRS_TORQUE) && (i_torque_source_sel == TS_INTERNAL);
      o_torque_ref      <= ((mode_q == TSRS_TORQUE) && (i_torque_source_sel == TS_INTERNAL)) ? trq_rd : TRQ_DEF;
      o_speed_zero      <= (mode_q != TSRS_INT_SPEED) || (spd_code_q == 3'h0);
      o_speed_ref       <= ((mode_q == TSRS_INT_SPEED) && (spd_code_q != 3'h0)) ? spd_rd : TRQ_DEF;
    end
  end

  // guards on limit, preset, mode and pin paths
  int_cap_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_torque_source_sel != TS_INTERNAL && lim_src_q != LS_EXTERNAL) |=> o_speed_limit == $past(cap_eff))
    else $error("internal cap limit wrong");
  ext_min_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_torque_source_sel != TS_INTERNAL && lim_src_q == LS_EXTERNAL)
    |=> o_speed_limit <= $past(cap_eff) && o_speed_limit <= $past(analog_rpm))
    else $error("external limit not minimum");
  max_clamp_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ##1 o_speed_limit <= MOTOR_MAX_RPM)
    else $error("limit above motor maximum");
  cap_range_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_prm_we && i_prm_addr == PRM_CAP && i_prm_wdata > CAP_MAX |=> $stable(cap_q))
    else $error("cap took out of range value");
  polarity_a: assert property (@(posedge i_clk) disable iff (i_reset)
    analog_rpm == scale_analog(-i_analog_speed_mv, gain_q) && analog_rpm >= 0)
    else $error("analog limit depends on sign");
  int_torque_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (mode_q == TSRS_TORQUE && i_torque_source_sel == TS_INTERNAL) |=> o_torque_internal && o_torque_ref == $past(trq_rd))
    else $error("internal torque not applied");
  trq_range_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_prm_we && i_prm_addr < PRM_SPD1 && !in_range(i_prm_wdata, TRQ_MIN, TRQ_MAX) |-> !mem_we ##1 o_prm_reject)
    else $error("torque preset range not enforced");
  zero_speed_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (mode_q == TSRS_INT_SPEED && spd_code == 3'h0 && !i_restart) |=> ##1 o_speed_zero && o_speed_ref == 16'sh0000)
    else $error("zero selection did not stop");
  mode_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_restart |=> $stable(mode_q) && $stable(lim_src_q))
    else $error("mode changed without restart");
  // only judged once two edges out of reset have refilled both stages
  pin_sync_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !$past(i_reset) && !$past(i_reset, 2) |-> sync2_q[SYNC_W-1] == $past(i_direction_sel_in, 2))
    else $error("direction not two-stage synchronised");
endmodule
`default_nettype wire

// ---- hdl/tsrs_pkg.sv ----
// Purpose: constants, parameter indices and helpers for the torque/speed reference selector
// Assumes: parameters are written one word at a time on a same-clock write port
// Notes:   signed 16-bit values everywhere; speeds in rpm, torques in percent
// Contract
// - source 0 uses speed cap alone
// - source 1 uses min(analog speed, cap)
// - clamp effective limit to motor maximum speed
// - cap range 0..6000 rpm, default 1500
// - analog magnitude scaled by gain, polarity ignored
// - torque mode plus source 1 uses internal torque
// - two selects pick torque preset 1..4
// - torque presets -400..400 percent, default 0
// - selects routed to pins by allocation words
// - internal torque limit chosen by two selects
// - limit presets -6000..6000, defaults 100/200/300/-100
// - seven stored speeds, picked by external inputs
// - mode 3 runs preset or zero speed
// - seven set speeds -6000..6000 with defaults
// - all selects off gives zero speed
package tsrs_pkg;
  typedef logic signed [15:0] tsrs_val_t;
  typedef logic [3:0]         tsrs_idx_t;

  // parameter indices on the write port
  localparam tsrs_idx_t PRM_TRQ1  = 4'h0;
  localparam tsrs_idx_t PRM_SPD1  = 4'h4;
  localparam tsrs_idx_t PRM_SPD7  = 4'ha;
  localparam tsrs_idx_t PRM_CAP   = 4'hb;
  localparam tsrs_idx_t PRM_GAIN  = 4'hc;
  localparam int        PRM_WORDS = 11;

  // ranges and defaults
  localparam tsrs_val_t CAP_MIN  = 16'sh0000;
  localparam tsrs_val_t CAP_MAX  = 16'sh1770;  // 6000
  localparam tsrs_val_t CAP_DEF  = 16'sh05dc;  // 1500
  localparam tsrs_val_t TRQ_MIN  = -16'sh0190; // -400
  localparam tsrs_val_t TRQ_MAX  = 16'sh0190;
  localparam tsrs_val_t TRQ_DEF  = 16'sh0000;
  localparam tsrs_val_t SPD_MIN  = -16'sh1770;
  localparam tsrs_val_t SPD_MAX  = 16'sh1770;
  localparam tsrs_val_t GAIN_MIN = 16'sh000a;  // 10 x 0.1 V
  localparam tsrs_val_t GAIN_MAX = 16'sh0064;  // 100 x 0.1 V
  localparam tsrs_val_t GAIN_DEF = 16'sh0021;  // 33
  localparam int        GAIN_LSB_MV = 100;     // one gain step is 0.1 V

  // mode field codes
  localparam logic [3:0] CM_TORQUE    = 4'h2;
  localparam logic [3:0] CM_INT_SPEED = 4'h3;
  localparam logic       LS_EXTERNAL  = 1'b1;
  localparam logic       TS_INTERNAL  = 1'b1;

  // pin allocation fields inside an allocation word
  localparam int ALLOC_SEL0_LSB = 0;
  localparam int ALLOC_SEL1_LSB = 4;
  localparam int PIN_IDX_W      = 3;

  typedef enum logic [1:0] {TSRS_IDLE, TSRS_TORQUE, TSRS_INT_SPEED} tsrs_mode_e;

  // reset value of each stored preset word
  function automatic tsrs_val_t prm_default(input int idx);
    case (idx)
      4:       prm_default = 16'sh0064;   // 100
      5:       prm_default = 16'sh00c8;   // 200
      6:       prm_default = 16'sh012c;   // 300
      7:       prm_default = -16'sh0064;  // -100
      8:       prm_default = -16'sh00c8;  // -200
      9:       prm_default = -16'sh012c;  // -300
      10:      prm_default = 16'sh01f4;   // 500
      default: prm_default = TRQ_DEF;
    endcase
  endfunction

  function automatic logic in_range(input tsrs_val_t v, input tsrs_val_t lo, input tsrs_val_t hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic tsrs_val_t smin(input tsrs_val_t a, input tsrs_val_t b);
    smin = (a < b) ? a : b;
  endfunction

  function automatic tsrs_val_t sabs(input tsrs_val_t a);
    sabs = (a < 0) ? -a : a;
  endfunction
endpackage

// ---- hdl/tsrs_prm_mem.sv ----
// Purpose: preset store: four torque presets then seven set speeds
// Assumes: writes are already range checked by the caller
// Notes:   two registered read ports; a write shows on a read one edge later
`timescale 1ns/1ps
`default_nettype none
module tsrs_prm_mem (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_we,
  input  wire tsrs_pkg::tsrs_idx_t i_waddr,
  input  wire tsrs_pkg::tsrs_val_t i_wdata,
  input  wire tsrs_pkg::tsrs_idx_t i_raddr_a,
  input  wire tsrs_pkg::tsrs_idx_t i_raddr_b,
  output var  tsrs_pkg::tsrs_val_t o_rdata_a,
  output var  tsrs_pkg::tsrs_val_t o_rdata_b
);
  import tsrs_pkg::*;

  tsrs_val_t mem_q [PRM_WORDS];

  // reset loads the defaults so the drive runs before any write
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < PRM_WORDS; k++) begin
      if (i_reset) begin
        mem_q[k] <= prm_default(k);
      end else if (i_we && (int'(i_waddr) == k)) begin
        mem_q[k] <= i_wdata;
      end
    end
  end

  // registered reads; out-of-map index reads zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata_a <= TRQ_DEF;
      o_rdata_b <= TRQ_DEF;
    end else begin
      o_rdata_a <= (int'(i_raddr_a) < PRM_WORDS) ? mem_q[i_raddr_a] : TRQ_DEF;
      o_rdata_b <= (int'(i_raddr_b) < PRM_WORDS) ? mem_q[i_raddr_b] : TRQ_DEF;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tsrs_host_model.sv ----
// Purpose: host controller model that drives the select pins and the analog speed reference
// Assumes: the bench changes commands just after a rising edge
// Notes:   pins are registered once, like a host output latch
`timescale 1ns/1ps
`default_nettype none
module tsrs_host_model (
  input  wire logic                i_clk,
  input  wire logic [10:0]         i_cmd,
  input  wire tsrs_pkg::tsrs_val_t i_mv,
  output logic                     o_direction_sel_in,
  output logic                     o_speed_sel_in_a,
  output logic                     o_speed_sel_in_b,
  output logic [7:0]               o_gp_pins,
  output tsrs_pkg::tsrs_val_t      o_analog_speed_mv
);
  import tsrs_pkg::*;
  // known levels before the first edge so the synchronisers never see unknowns
  initial begin
    {o_direction_sel_in, o_speed_sel_in_a, o_speed_sel_in_b, o_gp_pins} = 11'h000;
    o_analog_speed_mv = 16'sh0000;
  end

  // direction and speed selects as levels, held until the next command
  always @(posedge i_clk) begin
    {o_direction_sel_in, o_speed_sel_in_a, o_speed_sel_in_b, o_gp_pins} <= i_cmd;
    o_analog_speed_mv <= i_mv;
  end
endmodule
`default_nettype wire

// ---- dv/tsrs_top_test.sv ----
// Purpose: self-checking bench for the reference selector
// Assumes: pins come through the host model; outputs are levels once settled
// Notes:   waits exceed the fixed pin, write and restart latencies
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tsrs_top_test;
  import tsrs_pkg::*;
  typedef struct { logic [2:0] sel; tsrs_val_t v; } tsrs_note_s;
  localparam int MAXR = 3000;
  logic       clk = 0, rst = 1, restart = 0, lsrc = 0, tsrc = 0, we = 0, rej_seen = 0;
  logic [3:0] mode = 4'h0;
  logic [10:0] cmd = 11'h000;
  tsrs_idx_t  addr = 4'h0;
  tsrs_val_t  wdata = 16'sh0000, mv_cmd = 16'sh0000, mv, lim, trq, sref;
  logic       dir, sa, sb, tint, szero, rej;
  logic [7:0] gp;
  logic [7:0] alloc_a = 8'h10, alloc_b = 8'h32;
  int         seed = 19, errors = 0, comparisons = 0, cycles = 0, cap = 1500, gain = 33;
  tsrs_val_t  prm [0:10] = '{0, 0, 0, 0, 100, 200, 300, -100, -200, -300, 500};
  tsrs_note_s notes [$];

  tsrs_host_model host_u (.i_clk(clk), .i_cmd(cmd), .i_mv(mv_cmd), .o_direction_sel_in(dir),
    .o_speed_sel_in_a(sa), .o_speed_sel_in_b(sb), .o_gp_pins(gp), .o_analog_speed_mv(mv));
  // allocation starts with torque selects on pins 0/1, limit selects on pins 2/3
  tsrs_top #(.MOTOR_MAX_RPM(16'(MAXR)), .RATED_RPM(3000)) dut_u (.i_clk(clk), .i_reset(rst),
    .i_restart(restart), .i_control_mode_sel(mode), .i_speed_limit_source_sel(lsrc),
    .i_torque_source_sel(tsrc), .i_input_alloc_a(alloc_a), .i_input_alloc_b(alloc_b),
    .i_prm_we(we), .i_prm_addr(addr), .i_prm_wdata(wdata), .i_gp_pins(gp),
    .i_direction_sel_in(dir), .i_speed_sel_in_a(sa), .i_speed_sel_in_b(sb),
    .i_analog_speed_mv(mv), .o_speed_limit(lim), .o_torque_ref(trq), .o_torque_internal(tint),
    .o_speed_ref(sref), .o_speed_zero(szero), .o_prm_reject(rej));

  // 20 MHz clock
  always #25 clk = ~clk;

  // hang guard, about eight times the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end

  // monitor: reject pulses are gathered so one-cycle pulses are never missed
  always @(negedge clk) begin
    tsrs_note_s n;
    if (!rst) rej_seen = rej_seen | rej;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: `CHK(lim, n.v)
        1: `CHK(trq, n.v)
        2: `CHK(sref, n.v)
        3: `CHK({15'h0, szero}, n.v)
        4: begin
          `CHK({15'h0, rej_seen}, n.v)
          rej_seen = 0;
        end
        default: `CHK({15'h0, tint}, n.v)
      endcase
    end
  end

  task automatic wrap_up();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic note(input logic [2:0] s, input tsrs_val_t v);
    notes.push_back('{s, v});
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // magnitude limited to an upper bound
  function automatic tsrs_val_t clip(input int v, input int hi);
    v = v < 0 ? -v : v;
    return 16'(v > hi ? hi : v);
  endfunction

  function automatic tsrs_val_t ext_lim(input int m);
    int l;
    l = (m < 0 ? -m : m) * 3000 / (gain * 100);
    return clip(l > 6000 ? 6000 : l, cap > MAXR ? MAXR : cap);
  endfunction

  // one write strobe, then the reject flag is checked after it settles
  task automatic wr(input tsrs_idx_t a, input tsrs_val_t d, input logic bad);
    we <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 0;
    if (!bad && a == PRM_CAP) cap = d;
    else if (!bad && a == PRM_GAIN) gain = d;
    else if (!bad) prm[a] = d;
    repeat (4) @(posedge clk);
    note(4, {15'h0, bad});
  endtask

  task automatic pins(input logic [10:0] c, input tsrs_val_t m);
    cmd <= c;
    mv_cmd <= m;
    repeat (7) @(posedge clk);
  endtask

  task automatic go(input logic [3:0] m, input logic l);
    mode <= m;
    lsrc <= l;
    restart <= 1;
    @(posedge clk);
    restart <= 0;
    repeat (4) @(posedge clk);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    note(0, 16'sd1500);
    note(1, 16'sh0000);
    pins({3'h5, 8'h00}, 16'sh0000);
    note(3, 16'sh0001);
    note(2, 16'sh0000);
    done("reset");
    for (int p = 0; p < 2; p++) begin
      go(CM_INT_SPEED, 1'b0);
      for (int c = 0; c < 8; c++) begin
        pins({c[2:0], 8'h00}, 16'sh0000);
        note(2, c == 0 ? 16'sh0000 : prm[c + 3]);
        note(3, {15'h0, c == 0});
      end
      for (int i = 4; i < 11; i++) wr(i[3:0], 16'($random(seed) % 6001), 1'b0);
      done("set speed");
    end
    go(CM_TORQUE, 1'b0);
    wr(PRM_CAP, 16'sd2000, 1'b0);
    note(0, 16'sd2000);
    wr(PRM_CAP, 16'sd7000, 1'b1);
    wr(4'hd, 16'sh0001, 1'b1);
    wr(PRM_TRQ1, 16'sd401, 1'b1);
    wr(PRM_SPD1, -16'sd6001, 1'b1);
    note(0, 16'sd2000);
    wr(PRM_CAP, 16'sd6000, 1'b0);
    note(0, 16'(MAXR));
    lsrc <= 1;
    pins(11'h000, 16'sd100);
    note(0, 16'(MAXR));
    go(CM_TORQUE, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(PRM_GAIN, 16'(($random(seed) & 63) + 10), 1'b0);
      wr(PRM_CAP, 16'($random(seed) & 4095), 1'b0);
      pins(11'h000, 16'($random(seed) % 10001));
      note(0, ext_lim(mv_cmd));
    end
    done("speed cap");
    for (int i = 0; i < 4; i++) wr(i[3:0], 16'($random(seed) % 401), 1'b0);
    tsrc <= 1;
    // second pass moves all four selects to pins 4..7
    for (int r = 0; r < 2; r++) begin
      alloc_a <= r ? 8'h54 : 8'h10;
      alloc_b <= r ? 8'h76 : 8'h32;
      for (int k = 0; k < 4; k++) begin
        pins(11'({2'(3 - k), 2'(k)}) << (4 * r), 16'sh0000);
        note(1, prm[k]);
        note(5, 16'sh0001);
        note(0, clip(prm[7 - k], MAXR));
      end
    end
    tsrc <= 0;
    repeat (3) @(posedge clk);
    note(5, 16'sh0000);
    note(1, 16'sh0000);
    done("torque preset");
    tsrc <= 1;
    go(4'h1, 1'b0);
    note(5, 16'sh0000);
    note(1, 16'sh0000);
    note(3, 16'sh0001);
    done("idle mode");
    // mid-run reset must bring back cap and preset defaults
    tsrc <= 0;
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    note(0, 16'sd1500);
    go(CM_INT_SPEED, 1'b0);
    pins({3'h7, 8'h00}, 16'sh0000);
    note(2, 16'sd500);
    note(3, 16'sh0000);
    done("mid reset");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
